// File: common/ea_pkg.sv
// Package: addressing modes, operation classes, request and result carriers
package ea_pkg;

    // ****************************************************************
    // Address constants
    // ****************************************************************
    localparam logic [7:0]  ABS8_PAGE      = 8'hff;
    localparam logic [7:0]  MEMIND_PAGE    = 8'h00;
    localparam logic [15:0] STEP_BYTE      = 16'h0001;
    localparam logic [15:0] STEP_WORD      = 16'h0002;
    localparam logic [15:0] SMALL_ONE      = 16'h0001;
    localparam logic [15:0] SMALL_TWO      = 16'h0002;
    localparam logic [15:0] WORD_ALIGN     = 16'hfffe;
    localparam logic [15:0] RESET_WORD     = 16'h0000;
    localparam logic [2:0]  BIT_NUM_RESET  = 3'h0;
    localparam int          BIT_NUM_LSB    = 0;
    localparam int          BIT_NUM_MSB    = 2;
    localparam int          SIGN_BIT       = 7;

    // ****************************************************************
    // Modes and classes
    // ****************************************************************
    typedef enum logic [3:0] {
        MODE_REG,
        MODE_IND,
        MODE_DISP,
        MODE_POSTINC,
        MODE_PREDEC,
        MODE_ABS8,
        MODE_ABS16,
        MODE_IMM8,
        MODE_IMM16,
        MODE_PCREL,
        MODE_MEMIND
    } ea_mode_t;

    typedef enum logic [3:0] {
        OP_BYTE_MOVE,
        OP_WORD_MOVE,
        OP_WORD_ARITH,
        OP_ADDR_SMALL,
        OP_MULDIV,
        OP_ALU_IMM,
        OP_ALU_REG,
        OP_BIT_MANIP,
        OP_BIT_REGNUM,
        OP_JUMP,
        OP_BRANCH
    } op_class_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        ea_mode_t    mode;
        op_class_t   op;
        logic [3:0]  reg_sel;
        logic [15:0] reg_val;
        logic [7:0]  byte2;
        logic [2:0]  bit_imm;
        logic        bit_from_reg;
        logic [7:0]  bit_reg_val;
        logic        small_two;
        logic [15:0] ext_addr;
        logic [15:0] next_pc;
    } ea_req_t;

    typedef struct packed {
        logic [15:0] ea;
        logic [15:0] operand;
        logic        wb_en;
        logic [15:0] wb_val;
        logic [2:0]  bit_num;
        logic        is_mem;
        logic        branch;
        logic        illegal;
    } ea_rsp_t;

endpackage : ea_pkg

// File: logic/cpu_effective_address_unit.sv
// Effective-address unit: mode decode, address forming, register update
`timescale 1ns/1ps

module cpu_effective_address_unit (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            req_valid_i,
    input  wire ea_pkg::ea_req_t req_i,
    output logic                 req_ready_o,
    output logic                 rsp_valid_o,
    output ea_pkg::ea_rsp_t      rsp_o,
    output logic                 mem_req_o,
    output logic [15:0]          mem_addr_o,
    input  wire logic            mem_ack_i,
    input  wire logic [15:0]     mem_rdata_i
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic is_word(input ea_pkg::op_class_t op);
        case (op)
            ea_pkg::OP_WORD_MOVE,
            ea_pkg::OP_WORD_ARITH,
            ea_pkg::OP_ADDR_SMALL,
            ea_pkg::OP_MULDIV: is_word = 1'b1;
            default:           is_word = 1'b0;
        endcase
    endfunction : is_word

    function automatic logic is_move(input ea_pkg::op_class_t op);
        is_move = (op == ea_pkg::OP_BYTE_MOVE) || (op == ea_pkg::OP_WORD_MOVE);
    endfunction : is_move

    function automatic logic is_bit(input ea_pkg::op_class_t op);
        is_bit = (op == ea_pkg::OP_BIT_MANIP) || (op == ea_pkg::OP_BIT_REGNUM);
    endfunction : is_bit

    function automatic logic mode_legal(input ea_pkg::ea_req_t r);
        logic ok;
        ok = 1'b0;
        case (r.mode)
            ea_pkg::MODE_REG:     ok = (r.op != ea_pkg::OP_JUMP)
                                       && (r.op != ea_pkg::OP_BRANCH);
            ea_pkg::MODE_IND:     ok = is_move(r.op) || is_bit(r.op)
                                       || (r.op == ea_pkg::OP_JUMP);
            ea_pkg::MODE_DISP,
            ea_pkg::MODE_POSTINC,
            ea_pkg::MODE_PREDEC:  ok = is_move(r.op);
            ea_pkg::MODE_ABS8:    ok = (r.op == ea_pkg::OP_BYTE_MOVE)
                                       || is_bit(r.op);
            ea_pkg::MODE_ABS16:   ok = is_move(r.op)
                                       || (r.op == ea_pkg::OP_JUMP);
            ea_pkg::MODE_IMM8:    ok = (r.op == ea_pkg::OP_BYTE_MOVE)
                                       || (r.op == ea_pkg::OP_ALU_IMM);
            ea_pkg::MODE_IMM16:   ok = (r.op == ea_pkg::OP_WORD_MOVE);
            ea_pkg::MODE_PCREL:   ok = (r.op == ea_pkg::OP_BRANCH);
            ea_pkg::MODE_MEMIND:  ok = (r.op == ea_pkg::OP_JUMP);
            default:              ok = 1'b0;
        endcase
        // Register bit number only for the four basic bit ops, register form
        if (r.bit_from_reg && !((r.op == ea_pkg::OP_BIT_REGNUM)
                                && (r.mode == ea_pkg::MODE_REG))) begin
            ok = 1'b0;
        end
        mode_legal = ok;
    endfunction : mode_legal

    function automatic logic needs_ext(input ea_pkg::ea_mode_t m);
        needs_ext = (m == ea_pkg::MODE_DISP) || (m == ea_pkg::MODE_ABS16)
                    || (m == ea_pkg::MODE_IMM16);
    endfunction : needs_ext

    function automatic logic [15:0] align(input logic [15:0] a, input logic force_even);
        align = force_even ? (a & ea_pkg::WORD_ALIGN) : a;
    endfunction : align

    // ****************************************************************
    // Address and operand forming
    // ****************************************************************
    function automatic ea_pkg::ea_rsp_t evaluate(input ea_pkg::ea_req_t r,
                                                 input logic [15:0] ext,
                                                 input logic [15:0] ind);
        ea_pkg::ea_rsp_t o;
        logic            word;
        logic [15:0]     step;
        logic [15:0]     raw;
        o      = '0;
        word   = is_word(r.op);
        step   = word ? ea_pkg::STEP_WORD : ea_pkg::STEP_BYTE;
        raw    = ea_pkg::RESET_WORD;
        case (r.mode)
            ea_pkg::MODE_REG: begin
                // Low byte select in bit 3 of the register field
                o.operand = word ? r.reg_val
                          : {8'h00, (r.reg_sel[3] ? r.reg_val[7:0] : r.reg_val[15:8])};
            end
            ea_pkg::MODE_IND: begin
                raw = r.reg_val;
            end
            ea_pkg::MODE_DISP: begin
                raw = r.reg_val + ext;
            end
            ea_pkg::MODE_POSTINC: begin
                raw      = r.reg_val;
                o.wb_en  = 1'b1;
                o.wb_val = r.reg_val + step;
            end
            ea_pkg::MODE_PREDEC: begin
                o.wb_en  = 1'b1;
                o.wb_val = r.reg_val - step;
                raw      = r.reg_val - step;
            end
            ea_pkg::MODE_ABS8: begin
                raw = {ea_pkg::ABS8_PAGE, r.byte2};
            end
            ea_pkg::MODE_ABS16: begin
                raw = ext;
            end
            ea_pkg::MODE_IMM8: begin
                o.operand = {8'h00, r.byte2};
            end
            ea_pkg::MODE_IMM16: begin
                o.operand = ext;
            end
            ea_pkg::MODE_PCREL: begin
                // Range left to software; an odd target has bit 0 cleared by the branch alignment below
                raw = r.next_pc + {{8{r.byte2[ea_pkg::SIGN_BIT]}}, r.byte2};
            end
            ea_pkg::MODE_MEMIND: begin
                raw = ind;
            end
            default: begin
                raw = ea_pkg::RESET_WORD;
            end
        endcase
        o.is_mem = (r.mode != ea_pkg::MODE_REG) && (r.mode != ea_pkg::MODE_IMM8)
                   && (r.mode != ea_pkg::MODE_IMM16)
                   && (r.mode != ea_pkg::MODE_PCREL) && (r.mode != ea_pkg::MODE_MEMIND);
        o.branch = (r.op == ea_pkg::OP_JUMP) || (r.op == ea_pkg::OP_BRANCH);
        // Word data and code always sit on even addresses
        o.ea     = align(raw, (word && o.is_mem) || o.branch);
        if (r.op == ea_pkg::OP_ADDR_SMALL) begin
            o.operand = r.small_two ? ea_pkg::SMALL_TWO : ea_pkg::SMALL_ONE;
        end
        if (is_bit(r.op)) begin
            o.bit_num = r.bit_from_reg ? r.bit_reg_val[ea_pkg::BIT_NUM_MSB:ea_pkg::BIT_NUM_LSB]
                                       : r.bit_imm;
        end
        // Stack pointer walks assume word size from software
        if (!mode_legal(r)) begin
            o         = '0;
            o.illegal = 1'b1;
        end
        evaluate = o;
    endfunction : evaluate

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH_EXT,
        ST_FETCH_IND,
        ST_FINISH
    } ea_state_t;

    ea_state_t       state_r;
    ea_state_t       state_nxt;
    ea_pkg::ea_req_t req_r;
    ea_pkg::ea_req_t req_nxt;
    ea_pkg::ea_rsp_t rsp_r;
    ea_pkg::ea_rsp_t rsp_nxt;
    logic [15:0]     ext_r;
    logic [15:0]     ext_nxt;
    logic [15:0]     ind_r;
    logic [15:0]     ind_nxt;
    logic [15:0]     mem_addr_r;
    logic [15:0]     mem_addr_nxt;
    logic            rsp_valid_r;
    logic            rsp_valid_nxt;
    logic            accept;

    assign accept      = req_valid_i && (state_r == ST_IDLE);
    assign req_ready_o = (state_r == ST_IDLE);
    assign mem_req_o   = (state_r == ST_FETCH_EXT) || (state_r == ST_FETCH_IND);
    assign mem_addr_o  = mem_addr_r;
    assign rsp_valid_o = rsp_valid_r;
    assign rsp_o       = rsp_r;

    always_comb begin
        state_nxt     = state_r;
        req_nxt       = req_r;
        rsp_nxt       = rsp_r;
        ext_nxt       = ext_r;
        ind_nxt       = ind_r;
        mem_addr_nxt  = mem_addr_r;
        rsp_valid_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (req_valid_i) begin
                    req_nxt = req_i;
                    ext_nxt = ea_pkg::RESET_WORD;
                    ind_nxt = ea_pkg::RESET_WORD;
                    // Illegal combinations skip the bus entirely
                    if (mode_legal(req_i) && needs_ext(req_i.mode)) begin
                        state_nxt    = ST_FETCH_EXT;
                        mem_addr_nxt = align(req_i.ext_addr, 1'b1);
                    end else if (mode_legal(req_i) && (req_i.mode == ea_pkg::MODE_MEMIND)) begin
                        state_nxt    = ST_FETCH_IND;
                        mem_addr_nxt = align({ea_pkg::MEMIND_PAGE, req_i.byte2}, 1'b1);
                    end else begin
                        state_nxt = ST_FINISH;
                    end
                end
            end
            ST_FETCH_EXT: begin
                if (mem_ack_i) begin
                    ext_nxt   = mem_rdata_i;
                    state_nxt = ST_FINISH;
                end
            end
            ST_FETCH_IND: begin
                if (mem_ack_i) begin
                    ind_nxt   = mem_rdata_i;
                    state_nxt = ST_FINISH;
                end
            end
            ST_FINISH: begin
                rsp_nxt       = evaluate(req_r, ext_r, ind_r);
                rsp_valid_nxt = 1'b1;
                state_nxt     = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r     <= ST_IDLE;
            req_r       <= '0;
            rsp_r       <= '0;
            ext_r       <= ea_pkg::RESET_WORD;
            ind_r       <= ea_pkg::RESET_WORD;
            mem_addr_r  <= ea_pkg::RESET_WORD;
            rsp_valid_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            req_r       <= req_nxt;
            rsp_r       <= rsp_nxt;
            ext_r       <= ext_nxt;
            ind_r       <= ind_nxt;
            mem_addr_r  <= mem_addr_nxt;
            rsp_valid_r <= rsp_valid_nxt;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic ok_out;
    assign ok_out = rsp_valid_o && !rsp_o.illegal;

    sequence fetch_done_s;
        mem_req_o && mem_ack_i;
    endsequence

    sequence finish_then_rsp_s;
        !mem_req_o ##1 rsp_valid_o;
    endsequence

    fetch_to_rsp_a: assert property (fetch_done_s |=> finish_then_rsp_s)
        else $error("answer not two cycles after fetch ack");
    direct_rsp_a: assert property (accept && !needs_ext(req_i.mode)
                                   && (req_i.mode != ea_pkg::MODE_MEMIND)
                                   |=> !mem_req_o ##1 rsp_valid_o)
        else $error("direct mode answer late or fetched");
    reg_direct_a: assert property (ok_out && (req_r.mode == ea_pkg::MODE_REG)
                                   && is_word(req_r.op) && (req_r.op != ea_pkg::OP_ADDR_SMALL)
                                   |-> rsp_o.operand == req_r.reg_val)
        else $error("word register operand wrong");
    small_add_a: assert property (ok_out && (req_r.op == ea_pkg::OP_ADDR_SMALL)
                                  |-> rsp_o.operand == (req_r.small_two ? 16'h0002 : 16'h0001))
        else $error("implied small value wrong");
    reg_ind_a: assert property (ok_out && (req_r.mode == ea_pkg::MODE_IND) && !rsp_o.branch
                                && !is_word(req_r.op) |-> rsp_o.ea == req_r.reg_val)
        else $error("indirect address wrong");
    post_inc_a: assert property (ok_out && (req_r.mode == ea_pkg::MODE_POSTINC)
                                 |-> rsp_o.wb_en && (rsp_o.wb_val - rsp_o.ea
                                     == (is_word(req_r.op) ? 16'h0002 : 16'h0001)))
        else $error("post-increment step wrong");
    pre_dec_a: assert property (ok_out && (req_r.mode == ea_pkg::MODE_PREDEC)
                                && !is_word(req_r.op)
                                |-> rsp_o.ea == rsp_o.wb_val
                                    && rsp_o.wb_val == req_r.reg_val - 16'h0001)
        else $error("pre-decrement address wrong");
    abs_short_a: assert property (ok_out && (req_r.mode == ea_pkg::MODE_ABS8)
                                  |-> rsp_o.ea[15:8] == 8'hff)
        else $error("short absolute page wrong");
    imm_word_a: assert property (rsp_valid_o && (req_r.mode == ea_pkg::MODE_IMM16)
                                 && (req_r.op != ea_pkg::OP_WORD_MOVE) |-> rsp_o.illegal)
        else $error("word immediate accepted off move");
    pc_rel_a: assert property (ok_out && (req_r.mode == ea_pkg::MODE_PCREL)
                               |-> rsp_o.ea == ((req_r.next_pc
                                   + {{8{req_r.byte2[7]}}, req_r.byte2}) & 16'hfffe))
        else $error("relative target wrong");
    zero_page_a: assert property ((state_r == ST_FETCH_IND) |-> mem_addr_o[15:8] == 8'h00)
        else $error("indirect table read off zero page");
    even_word_a: assert property (ok_out && (rsp_o.branch || (is_word(req_r.op)
                                  && rsp_o.is_mem)) |-> !rsp_o.ea[0])
        else $error("word or branch address odd");
    bit_reg_a: assert property (ok_out && req_r.bit_from_reg
                                |-> rsp_o.bit_num == req_r.bit_reg_val[2:0])
        else $error("register bit number wrong");

endmodule : cpu_effective_address_unit

// File: sim/cpu_effective_address_unit_tb.sv
// Self-checking bench for the effective-address unit
`timescale 1ns/1ps

module cpu_effective_address_unit_tb;
    logic            clk_i;
    logic            rst_i;
    logic            req_valid_i;
    ea_pkg::ea_req_t req_i;
    logic            req_ready_o;
    logic            rsp_valid_o;
    ea_pkg::ea_rsp_t rsp_o;
    logic            mem_req_o;
    logic [15:0]     mem_addr_o;
    logic            mem_ack_i;
    logic [15:0]     mem_rdata_i;
    logic [2:0]      mem_wait;
    logic [31:0]     seed;
    int              mismatches;
    int              samples_checked;
    ea_pkg::ea_rsp_t exp_q[$];
    ea_pkg::ea_rsp_t msk_q[$];

    cpu_effective_address_unit uut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
        .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
        .mem_rdata_i(mem_rdata_i));
    ea_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .mem_req_i(mem_req_o),
        .mem_addr_i(mem_addr_o), .wait_i(mem_wait), .mem_ack_o(mem_ack_i),
        .mem_rdata_o(mem_rdata_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ****************************************************************
    // Stimulus and prediction
    // ****************************************************************
    function automatic logic [31:0] rnd();
        repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd

    function automatic logic legal(input ea_pkg::ea_req_t r);
        logic mv;
        logic bt;
        mv = r.op inside {ea_pkg::OP_BYTE_MOVE, ea_pkg::OP_WORD_MOVE};
        bt = r.op inside {ea_pkg::OP_BIT_MANIP, ea_pkg::OP_BIT_REGNUM};
        if (r.bit_from_reg && !(r.mode == ea_pkg::MODE_REG && r.op == ea_pkg::OP_BIT_REGNUM))
            return 1'b0;
        case (r.mode)
            ea_pkg::MODE_REG:    return !(r.op inside {ea_pkg::OP_JUMP, ea_pkg::OP_BRANCH});
            ea_pkg::MODE_IND:    return mv || bt || r.op == ea_pkg::OP_JUMP;
            ea_pkg::MODE_ABS8:   return r.op == ea_pkg::OP_BYTE_MOVE || bt;
            ea_pkg::MODE_ABS16:  return mv || r.op == ea_pkg::OP_JUMP;
            ea_pkg::MODE_IMM8:   return r.op inside {ea_pkg::OP_BYTE_MOVE, ea_pkg::OP_ALU_IMM};
            ea_pkg::MODE_IMM16:  return r.op == ea_pkg::OP_WORD_MOVE;
            ea_pkg::MODE_PCREL:  return r.op == ea_pkg::OP_BRANCH;
            ea_pkg::MODE_MEMIND: return r.op == ea_pkg::OP_JUMP;
            default:             return mv;
        endcase
    endfunction : legal

    function automatic void predict(input ea_pkg::ea_req_t r, output ea_pkg::ea_rsp_t e,
                                    output ea_pkg::ea_rsp_t m);
        logic [15:0] st;
        logic [15:0] w;
        e = '0;
        m = '1;
        if (!legal(r)) begin
            e.illegal = 1'b1;
            return;
        end
        m = '0;
        m.illegal = 1'b1;
        m.wb_en = 1'b1;
        m.branch = 1'b1;
        m.ea = 16'hffff;
        st = (r.op == ea_pkg::OP_WORD_MOVE) ? 16'h0002 : 16'h0001;
        w = mem.word_at(r.ext_addr & 16'hfffe);
        case (r.mode)
            ea_pkg::MODE_REG: begin
                m.operand = 16'hffff;
                if (r.op == ea_pkg::OP_ADDR_SMALL)
                    e.operand = r.small_two ? 16'h0002 : 16'h0001;
                else if (r.op inside {ea_pkg::OP_WORD_MOVE, ea_pkg::OP_WORD_ARITH,
                                      ea_pkg::OP_MULDIV})
                    e.operand = r.reg_val;
                else begin
                    m.operand = 16'h00ff;
                    e.operand[7:0] = r.reg_sel[3] ? r.reg_val[7:0] : r.reg_val[15:8];
                end
            end
            ea_pkg::MODE_IND:     e.ea = r.reg_val;
            ea_pkg::MODE_DISP:    e.ea = r.reg_val + w;
            ea_pkg::MODE_POSTINC: e.ea = r.reg_val;
            ea_pkg::MODE_PREDEC:  e.ea = r.reg_val - st;
            ea_pkg::MODE_ABS8:    e.ea = {8'hff, r.byte2};
            ea_pkg::MODE_ABS16:   e.ea = w;
            ea_pkg::MODE_IMM8:    e.operand = {8'h00, r.byte2};
            ea_pkg::MODE_IMM16:   e.operand = w;
            ea_pkg::MODE_PCREL:   e.ea = r.next_pc + {{8{r.byte2[7]}}, r.byte2};
            default:              e.ea = mem.word_at({8'h00, r.byte2} & 16'hfffe);
        endcase
        if (r.mode inside {ea_pkg::MODE_REG, ea_pkg::MODE_IMM8, ea_pkg::MODE_IMM16}) begin
            m.ea = 16'h0000;
            m.operand = (r.mode == ea_pkg::MODE_IMM8) ? 16'h00ff : 16'hffff;
        end
        if (r.mode == ea_pkg::MODE_POSTINC || r.mode == ea_pkg::MODE_PREDEC) begin
            e.wb_en = 1'b1;
            m.wb_val = 16'hffff;
            e.wb_val = (r.mode == ea_pkg::MODE_POSTINC) ? r.reg_val + st : r.reg_val - st;
        end
        e.branch = r.op inside {ea_pkg::OP_JUMP, ea_pkg::OP_BRANCH};
        if (r.op inside {ea_pkg::OP_WORD_MOVE, ea_pkg::OP_JUMP, ea_pkg::OP_BRANCH})
            e.ea = e.ea & 16'hfffe;
        m.is_mem = !e.branch;
        e.is_mem = r.mode >= ea_pkg::MODE_IND && r.mode <= ea_pkg::MODE_ABS16;
        if (r.op inside {ea_pkg::OP_BIT_MANIP, ea_pkg::OP_BIT_REGNUM}) begin
            m.bit_num = 3'h7;
            e.bit_num = r.bit_from_reg ? r.bit_reg_val[2:0] : r.bit_imm;
        end
    endfunction : predict

    function automatic ea_pkg::ea_req_t rand_req(input int md, input int op);
        ea_pkg::ea_req_t r;
        logic [95:0]     v;
        logic [15:0]     w;
        v = {rnd(), rnd(), rnd()};
        r = v[$bits(ea_pkg::ea_req_t)-1:0];
        r.mode = ea_pkg::ea_mode_t'(md);
        r.op = ea_pkg::op_class_t'(op);
        r.bit_from_reg = r.bit_from_reg & (r.op == ea_pkg::OP_BIT_REGNUM);
        if (r.mode inside {ea_pkg::MODE_POSTINC, ea_pkg::MODE_PREDEC}) begin
            if (r.reg_sel[2:0] == 3'h7) r.op = ea_pkg::OP_WORD_MOVE;
            if (r.op == ea_pkg::OP_WORD_MOVE) r.reg_val[0] = 1'b0;
        end
        w = mem.word_at(r.ext_addr & 16'hfffe);
        if (r.mode == ea_pkg::MODE_DISP && r.op == ea_pkg::OP_WORD_MOVE) r.reg_val[0] = w[0];
        if (r.mode == ea_pkg::MODE_PCREL) r.byte2[0] = 1'b0;
        return r;
    endfunction : rand_req

    task automatic send(input ea_pkg::ea_req_t r);
        ea_pkg::ea_rsp_t e;
        ea_pkg::ea_rsp_t m;
        logic [31:0]     s;
        predict(r, e, m);
        s = rnd();
        req_valid_i <= 1'b1;
        req_i <= r;
        mem_wait <= s[2:0];
        do @(posedge clk_i); while (req_ready_o !== 1'b1);
        exp_q.push_back(e);
        msk_q.push_back(m);
        if (s[4]) begin
            // A gap now and then; otherwise requests run back to back
            req_valid_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask : send

    task automatic one(input int md, input int op, input logic [15:0] v, input logic [7:0] b,
                       input logic f);
        ea_pkg::ea_req_t r;
        r = rand_req(md, op);
        r.reg_val = v;
        r.next_pc = v;
        r.ext_addr = v;
        r.byte2 = b;
        r.bit_reg_val = b;
        r.small_two = f;
        r.bit_from_reg = f & (op inside {ea_pkg::OP_BIT_MANIP, ea_pkg::OP_BIT_REGNUM});
        if (r.op == ea_pkg::OP_WORD_MOVE && md inside {ea_pkg::MODE_POSTINC, ea_pkg::MODE_PREDEC})
            r.reg_val[0] = 1'b0;
        send(r);
    endtask : one

    // ****************************************************************
    // Checking and verdict
    // ****************************************************************
    task automatic compare_rsp(input ea_pkg::ea_rsp_t g, input ea_pkg::ea_rsp_t e,
                               input ea_pkg::ea_rsp_t m);
        samples_checked++;
        if ((g & m) !== (e & m)) begin
            mismatches++;
            $display("wrong value at %0t: answer %h, expected %h", $time, g & m, e & m);
        end
    endtask : compare_rsp

    task automatic compare_addr(input logic [15:0] g);
        samples_checked++;
        if (g[0] !== 1'b0) begin
            mismatches++;
            $display("wrong value at %0t: odd read address %h", $time, g);
        end
    endtask : compare_addr

    always @(posedge clk_i) begin
        if (!rst_i && rsp_valid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("wrong value at %0t: answer without request", $time);
            end else
                compare_rsp(rsp_o, exp_q.pop_front(), msk_q.pop_front());
        end
        if (!rst_i && mem_req_o === 1'b1) compare_addr(mem_addr_o);
    end

    task automatic tally_and_finish();
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        seed = 32'h28adeb9f;
        mismatches = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        req_valid_i = 1'b0;
        req_i = '0;
        mem_wait = 3'h0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 3; k++)
            for (int md = 0; md < 11; md++)
                for (int op = 0; op < 11; op++)
                    send(rand_req(md, op));
        one(ea_pkg::MODE_IND, ea_pkg::OP_WORD_MOVE, 16'h1235, 8'h00, 1'b0);
        one(ea_pkg::MODE_DISP, ea_pkg::OP_BYTE_MOVE, 16'hffff, 8'h00, 1'b0);
        one(ea_pkg::MODE_POSTINC, ea_pkg::OP_BYTE_MOVE, 16'hffff, 8'h00, 1'b0);
        one(ea_pkg::MODE_POSTINC, ea_pkg::OP_WORD_MOVE, 16'hfffe, 8'h00, 1'b0);
        one(ea_pkg::MODE_PREDEC, ea_pkg::OP_BYTE_MOVE, 16'h0000, 8'h00, 1'b0);
        one(ea_pkg::MODE_PREDEC, ea_pkg::OP_WORD_MOVE, 16'h0000, 8'h00, 1'b0);
        one(ea_pkg::MODE_ABS8, ea_pkg::OP_BIT_MANIP, 16'h1234, 8'h00, 1'b0);
        one(ea_pkg::MODE_ABS8, ea_pkg::OP_BYTE_MOVE, 16'h1234, 8'hff, 1'b0);
        one(ea_pkg::MODE_PCREL, ea_pkg::OP_BRANCH, 16'h0000, 8'h80, 1'b0);
        one(ea_pkg::MODE_PCREL, ea_pkg::OP_BRANCH, 16'hffff, 8'h7e, 1'b0);
        one(ea_pkg::MODE_MEMIND, ea_pkg::OP_JUMP, 16'h1234, 8'hff, 1'b0);
        one(ea_pkg::MODE_REG, ea_pkg::OP_ADDR_SMALL, 16'h1234, 8'h00, 1'b0);
        one(ea_pkg::MODE_REG, ea_pkg::OP_ADDR_SMALL, 16'h1234, 8'h00, 1'b1);
        one(ea_pkg::MODE_REG, ea_pkg::OP_BIT_REGNUM, 16'h1234, 8'hfd, 1'b1);
        one(ea_pkg::MODE_REG, ea_pkg::OP_BIT_MANIP, 16'h1234, 8'hfd, 1'b1);
        one(ea_pkg::MODE_IND, ea_pkg::OP_BIT_REGNUM, 16'h1234, 8'hfd, 1'b1);
        one(ea_pkg::MODE_IMM8, ea_pkg::OP_ALU_IMM, 16'h1234, 8'ha5, 1'b0);
        one(ea_pkg::MODE_REG, ea_pkg::OP_MULDIV, 16'h8001, 8'h00, 1'b0);
        req_valid_i <= 1'b0;
        for (int w = 0; w < 40 && exp_q.size() != 0; w++) @(posedge clk_i);
        if (exp_q.size() != 0) mismatches++;
        tally_and_finish();
    end
endmodule : cpu_effective_address_unit_tb

// File: sim/ea_mem_model.sv
// Memory bus partner model: one word per read after a chosen wait
`timescale 1ns/1ps

module ea_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        mem_req_i,
    input  wire logic [15:0] mem_addr_i,
    input  wire logic [2:0]  wait_i,
    output logic             mem_ack_o,
    output logic [15:0]      mem_rdata_o
);
    logic [2:0] cnt_r;

    // Fixed contents, so the bench can predict every fetched word
    function automatic logic [15:0] word_at(input logic [15:0] a);
        return {a[7:0], a[15:8]} ^ 16'h3c5a;
    endfunction : word_at

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r       <= 3'h0;
            mem_ack_o   <= 1'b0;
            mem_rdata_o <= 16'h0f0f;
        end else if (mem_req_i && !mem_ack_o && cnt_r >= wait_i) begin
            mem_ack_o   <= 1'b1;
            mem_rdata_o <= word_at(mem_addr_i);
            cnt_r       <= 3'h0;
        end else begin
            // Data not valid outside the ack cycle, so keep it moving
            mem_ack_o   <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            cnt_r       <= (mem_req_i && !mem_ack_o) ? cnt_r + 3'h1 : 3'h0;
        end
    end
endmodule : ea_mem_model
